// >>> logic/fault_class_manager.sv
// fault classification, reporting and recovery with apb register access
//
// Our own choices: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "fault_class_cfg.svh"
module fault_class_manager
	import fault_class_pkg::*;
#(
	parameter int unsigned WD_BASE = `WD_BASE_CYC
)
(
	input wire logic clk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic gate_enable,
	input wire logic supply_lockout_level_two,
	input wire logic [3:0] temp_flag,
	input wire logic overtemp_warning,
	input wire logic overtemp_shutdown,
	input wire logic pump_undervoltage_warning,
	input wire logic supply_undervoltage_warning,
	input wire logic supply_overvoltage_warning,
	input wire logic pump_lockout,
	input wire logic [5:0] fet_drain_source_fault,
	input wire logic [2:0] source_sense_overcurrent,
	input wire logic [5:0] gate_mismatch,
	input wire logic regulator_undervoltage,
	output logic fault_indicator_n,
	output logic power_good_out,
	output logic gate_pulldown,
	output logic pump_enable,
	output logic driver_enable
);

	// ====================================
	// bus decode
	logic wr_hit;
	logic rd_hit;
	logic mapped;
	logic rd_warn;
	logic rd_vds;
	assign pready = 1'b1;
	assign mapped = (paddr == `ADDR_WARN) || (paddr == `ADDR_VDS) || (paddr == `ADDR_IC)
		|| (paddr == `ADDR_VGS) || (paddr == `ADDR_CTRL) || (paddr == `ADDR_STATE);
	assign pslverr = psel && penable && !mapped;
	assign wr_hit = psel && penable && pwrite;
	// reads act in the setup cycle so their data stands at the access edge
	assign rd_hit = psel && !penable && !pwrite;
	assign rd_warn = rd_hit && (paddr == `ADDR_WARN);
	assign rd_vds = rd_hit && (paddr == `ADDR_VDS);

	// ====================================
	// control fields
	logic clear_faults_bit;
	logic watchdog_enable_bit;
	logic [1:0] wd_dly;
	vds_mode_t vds_mode;
	logic gate_en_q;
	logic gate_rise;
	logic recover;
	logic wd_expire;
	logic release_done;
	dev_state_t state;
	assign gate_rise = gate_enable && !gate_en_q;
	// rising gate enable or clear-faults bit both recover
	assign recover = gate_rise || clear_faults_bit;

	// gate enable edge detect
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			gate_en_q <= 1'b0;
		else
			gate_en_q <= gate_enable;
	end

	// control register, self clearing clear bit and watchdog drop
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			clear_faults_bit <= 1'b0;
			watchdog_enable_bit <= 1'b0;
			wd_dly <= 2'h0;
			vds_mode <= VDS_LATCH;
		end
		else
		begin
			if (wr_hit && paddr == `ADDR_CTRL)
			begin
				clear_faults_bit <= pwdata[`CTRL_CLR_POS];
				watchdog_enable_bit <= pwdata[`CTRL_WATCHDOG_ENABLE_BIT_POS];
				wd_dly <= pwdata[`CTRL_WD_DLY_POS +: 2];
				vds_mode <= vds_mode_t'(pwdata[`CTRL_VDS_MODE_POS +: 2]);
			end
			else if (release_done)
				clear_faults_bit <= 1'b0;
			if (wd_expire)
				watchdog_enable_bit <= 1'b0;
		end
	end

	// ====================================
	// condition vectors
	logic [4:0] warn_cond;
	logic [5:0] vds_cond;
	logic [2:0] ic_cond;
	logic [4:0] lat_cond;
	logic [4:0] warn_st;
	logic [5:0] vds_st;
	logic [5:0] vgs_st;
	logic [2:0] ocp_st;
	logic [4:0] lat_st;
	logic watchdog_expired_bit;
	logic reg_uv_st;
	logic vds_latch_mode;
	assign vds_latch_mode = (vds_mode == VDS_LATCH);
	// warnings: supply uv, supply ov, pump uv, overtemp warning, vds report
	assign warn_cond = {supply_undervoltage_warning, supply_overvoltage_warning,
		pump_undervoltage_warning, overtemp_warning,
		(vds_mode == VDS_REPORT) && (|fet_drain_source_fault)};
	// disable mode masks drain-source entirely
	assign vds_cond = (vds_mode == VDS_DISABLE) ? 6'h00 : fet_drain_source_fault;
	// latched: level two lockout, overtemp shutdown, pump lockout
	assign lat_cond = {supply_lockout_level_two, overtemp_shutdown, pump_lockout, 2'b00};
	assign ic_cond = {regulator_undervoltage, 2'b00};

	// warning and report bits: set wins, clear on read only if gone
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			warn_st <= 5'h00;
		else
			warn_st <= warn_cond | (warn_st & ~((rd_warn || recover) ? ~warn_cond : 5'h00));
	end

	// drain-source bits: latch mode clears on recovery, report mode on read
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			vds_st <= 6'h00;
		else if ((vds_latch_mode && recover) || (!vds_latch_mode && (rd_vds || recover)))
			vds_st <= vds_cond;
		else
			vds_st <= vds_st | vds_cond;
	end

	// latched faults keep bit while condition persists through recovery
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			vgs_st <= 6'h00;
			ocp_st <= 3'h0;
			lat_st <= 5'h00;
			reg_uv_st <= 1'b0;
			watchdog_expired_bit <= 1'b0;
		end
		else if (recover)
		begin
			vgs_st <= gate_mismatch;
			ocp_st <= source_sense_overcurrent;
			lat_st <= lat_cond;
			reg_uv_st <= ic_cond[2];
			watchdog_expired_bit <= wd_expire;
		end
		else
		begin
			vgs_st <= vgs_st | gate_mismatch;
			ocp_st <= ocp_st | source_sense_overcurrent;
			lat_st <= lat_st | lat_cond;
			reg_uv_st <= reg_uv_st | ic_cond[2];
			watchdog_expired_bit <= watchdog_expired_bit | wd_expire;
		end
	end

	// ====================================
	// class summaries
	logic any_latched;
	logic any_pg_fault;
	logic pump_stop;
	logic any_warn;
	assign any_pg_fault = reg_uv_st || watchdog_expired_bit;
	assign pump_stop = (|vgs_st) || (|lat_st);
	assign any_latched = pump_stop || (|ocp_st) || any_pg_fault
		|| (vds_latch_mode && (|vds_st));
	assign any_warn = |warn_st;
	assign release_done = clear_faults_bit && !any_latched;
	// latched causes still present; a gate rise with one of them starts nothing
	logic fault_now;
	assign fault_now = (|gate_mismatch) || (|lat_cond)
		|| (|source_sense_overcurrent) || ic_cond[2] || wd_expire
		|| (vds_latch_mode && (|vds_cond));

	// ====================================
	// watchdog timer, restarted by status read
	logic [31:0] wd_cnt;
	logic [31:0] wd_limit;
	assign wd_limit = WD_BASE * ({30'h0, wd_dly} + 32'h1);
	assign wd_expire = watchdog_enable_bit && (wd_cnt >= wd_limit - 32'h1);
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			wd_cnt <= 32'h0;
		else if (!watchdog_enable_bit || rd_warn || wd_expire)
			wd_cnt <= 32'h0;
		else
			wd_cnt <= wd_cnt + 32'h1;
	end

	// ====================================
	// 64 us toggle timebase on internal clock
	logic [15:0] tick_cnt;
	logic blink;
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			tick_cnt <= 16'h0;
			blink <= 1'b0;
		end
		else if (!any_warn)
		begin
			tick_cnt <= 16'h0;
			blink <= 1'b0;
		end
		else if (tick_cnt == 16'(`HALF_CYC - 1))
		begin
			tick_cnt <= 16'h0;
			blink <= !blink;
		end
		else
			tick_cnt <= tick_cnt + 16'h1;
	end

	// power-good low pulse, at least 64 us from fault entry
	logic [15:0] pg_cnt;
	logic pg_entry;
	// regulator fault entry only, so a long fault does not stretch the pulse past recovery
	assign pg_entry = ic_cond[2] && !reg_uv_st;
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			pg_cnt <= 16'h0;
		else if (pg_entry || wd_expire)
			pg_cnt <= 16'(`PERIOD_CYC);
		else if (pg_cnt != 16'h0)
			pg_cnt <= pg_cnt - 16'h1;
	end

	// ====================================
	// device state sequence
	logic [7:0] start_cnt;
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			state <= ST_POWERUP;
			start_cnt <= 8'h0;
		end
		else
		begin
			unique case (state)
				ST_POWERUP:
				begin
					if (start_cnt != 8'hFF)
						start_cnt <= start_cnt + 8'h1;
					if (start_cnt >= 8'(`STARTUP_CYC - 1) && !supply_lockout_level_two)
						state <= ST_STANDBY;
				end
				ST_STANDBY:
					// the rise reloads latched bits, so judge on causes present now
					if (gate_rise && !fault_now)
						state <= ST_OPERATING;
				ST_OPERATING:
					if (!gate_enable || any_latched)
						state <= ST_STANDBY;
			endcase
		end
	end

	// ====================================
	// pin and enable outputs, registered
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			fault_indicator_n <= 1'b0;
			power_good_out <= 1'b1;
			gate_pulldown <= 1'b1;
			pump_enable <= 1'b0;
			driver_enable <= 1'b0;
		end
		else
		begin
			// temp flags take no part here
			if (state == ST_POWERUP || any_latched)
				fault_indicator_n <= 1'b0;
			else
				fault_indicator_n <= !blink;
			power_good_out <= (pg_cnt == 16'h0) && !reg_uv_st;
			gate_pulldown <= (state != ST_OPERATING);
			// pump starts with operation and runs on through latched faults that spare it
			pump_enable <= ((state == ST_OPERATING) || (pump_enable && gate_enable))
				&& !pump_stop;
			driver_enable <= (state == ST_OPERATING);
		end
	end

	// ====================================
	// read data, registered in the setup cycle
	logic [31:0] rd_mux;
	always_comb
	begin
		rd_mux = 32'h0;
		unique case (paddr)
			`ADDR_WARN: rd_mux = {21'h0, any_latched, 1'b0, temp_flag[3], warn_st[4],
				warn_st[3], warn_st[0], warn_st[2], temp_flag[0], temp_flag[1],
				temp_flag[2], warn_st[1]};
			`ADDR_VDS: rd_mux = {21'h0, vds_st, 2'b00, ocp_st};
			`ADDR_IC: rd_mux = {21'h0, lat_st[4], watchdog_expired_bit, lat_st[3], 1'b0,
				reg_uv_st, 3'b000, lat_st[2], 2'b00};
			`ADDR_VGS: rd_mux = {21'h0, vgs_st, 5'h00};
			`ADDR_CTRL: rd_mux = {18'h0, vds_mode, 5'h0, wd_dly, 1'b0,
				watchdog_enable_bit, 1'b0, clear_faults_bit, 1'b0};
			`ADDR_STATE: rd_mux = {29'h0, state};
			default: rd_mux = 32'h0;
		endcase
	end
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			prdata <= 32'h0;
		else if (rd_hit && mapped)
			prdata <= rd_mux;
	end

endmodule

// >>> logic/fault_class_cfg.svh
// constants for the fault class manager
//
// Contract
// - latched fault holds fault pin low; clears on gate-enable rise or clear-faults bit.
// - warning toggles fault pin with 64 us period until status 0x01 is read.
// - warning and report-only bits clear on read only if condition gone.
// - drain-source report mode acts as warning; outputs and pump keep running.
// - temperature flags follow their condition, never touch fault or power-good pins.
// - drain-source disable mode neither reports nor signals events.
// - watchdog and regulator undervoltage drive fault and power-good low 64 us min; watchdog pulse timed; fault pin and regulator power-good held to recovery.
// - latched status bits clear only when recovery succeeds.
// - drain-source latch mode and source overcurrent latch, pull gates, pump runs.
// - gate mismatch, overtemp shutdown, pump lockout latch and stop the charge pump.
// - pump, supply and overtemp warnings are warning class; all keeps running.
// - clear-faults write clears expired faults like a gate-enable low-high cycle.
// - clear-faults bit self clears once status reset and fault pin released.
// - during power-up gates held low and fault pin driven low.
// - startup done with supply above level two releases fault pin, enters standby.
// - standby on gate enable low or any latched fault.
// - gate enable rising starts operation, pump and driver enabled.
// - watchdog needs status read in interval, else latched plus power-good, enable clears.
`ifndef FAULT_CLASS_CFG_SVH
`define FAULT_CLASS_CFG_SVH

// ====================================
// bus map (byte addresses)
`define ADDR_WARN 12'h004
`define ADDR_VDS 12'h008
`define ADDR_IC 12'h00C
`define ADDR_VGS 12'h010
`define ADDR_CTRL 12'h024
`define ADDR_STATE 12'h040

// ====================================
// control register 0x9 field positions
`define CTRL_CLR_POS 1
`define CTRL_WATCHDOG_ENABLE_BIT_POS 3
`define CTRL_WD_DLY_POS 5
`define CTRL_VDS_MODE_POS 12
`define CTRL_RESET 32'h0000_0000

// ====================================
// timing
`define CLK_MHZ 20
`define PERIOD_US 64
`define PERIOD_CYC (`PERIOD_US * `CLK_MHZ)
`define HALF_CYC (`PERIOD_CYC / 2)
`define WD_BASE_MS 10
`define WD_BASE_CYC (`WD_BASE_MS * 1000 * `CLK_MHZ)
`define STARTUP_CYC 64

`endif

// >>> logic/fault_class_pkg.sv
// types for the fault class manager
package fault_class_pkg;
	typedef enum logic [2:0]
	{
		ST_POWERUP = 3'b001,
		ST_STANDBY = 3'b010,
		ST_OPERATING = 3'b100
	} dev_state_t;
	typedef enum logic [1:0]
	{
		VDS_LATCH = 2'h0,
		VDS_REPORT = 2'h1,
		VDS_DISABLE = 2'h2
	} vds_mode_t;
endpackage

// >>> tb/fault_class_manager_props.sv
// checker of the fault class manager port behaviour
`timescale 1ns/1ps
module fault_class_manager_props
(
	input wire logic clk,
	input wire logic rst,
	input wire logic gate_enable,
	input wire logic supply_lockout_level_two,
	input wire logic overtemp_shutdown,
	input wire logic pump_lockout,
	input wire logic [5:0] fet_drain_source_fault,
	input wire logic [2:0] source_sense_overcurrent,
	input wire logic [5:0] gate_mismatch,
	input wire logic regulator_undervoltage,
	input wire logic fault_indicator_n,
	input wire logic power_good_out,
	input wire logic gate_pulldown,
	input wire logic pump_enable,
	input wire logic driver_enable
);
	logic [6:0] up_cnt;
	logic [10:0] low_cnt;
	logic stop;
	logic quiet;
	// ==========
	// cycles since reset, saturating at 100
	always_ff @(posedge clk or posedge rst)
		if (rst)
			up_cnt <= 7'h00;
		else if (up_cnt != 7'h64)
			up_cnt <= up_cnt + 7'h01;
	// length of the current power-good low pulse
	always_ff @(posedge clk or posedge rst)
		if (rst)
			low_cnt <= 11'h000;
		else if (power_good_out)
			low_cnt <= 11'h000;
		else if (low_cnt != 11'h7FF)
			low_cnt <= low_cnt + 11'h001;
	// pump-stopping causes, and no latching cause at all
	assign stop = overtemp_shutdown | pump_lockout | (|gate_mismatch);
	assign quiet = !(stop | supply_lockout_level_two | regulator_undervoltage
		| (|fet_drain_source_fault) | (|source_sense_overcurrent));
	default clocking @(posedge clk);
	endclocking
	default disable iff (rst);
	a_powerup_hold: assert property (up_cnt < 7'h3C |-> gate_pulldown && !fault_indicator_n)
		else $error("power-up released gates or fault pin");
	a_powerup_done: assert property (up_cnt == 7'h50 && quiet |-> fault_indicator_n)
		else $error("fault pin held after clean power-up");
	a_standby_pull: assert property (!gate_enable [*4] |=> gate_pulldown && !driver_enable)
		else $error("gates not pulled down with gate enable low");
	a_start_run: assert property ($rose(gate_enable) && quiet && up_cnt == 7'h64
		|-> ##[1:4] driver_enable && pump_enable && !gate_pulldown)
		else $error("no start after gate enable rise");
	a_ocp_latch: assert property (|source_sense_overcurrent
		|-> ##[1:4] gate_pulldown && !fault_indicator_n)
		else $error("overcurrent not latched");
	a_pump_stop: assert property (stop |-> ##[1:4] !pump_enable && gate_pulldown)
		else $error("pump still running after stopping fault");
	a_reg_pg: assert property (regulator_undervoltage
		|-> ##[1:4] !power_good_out && !fault_indicator_n)
		else $error("regulator fault did not drop power-good");
	a_pg_width: assert property ($rose(power_good_out) |-> low_cnt >= 11'h500)
		else $error("power-good low pulse too short");
endmodule
bind fault_class_manager fault_class_manager_props u_props (.clk, .rst, .gate_enable,
	.supply_lockout_level_two, .overtemp_shutdown, .pump_lockout, .fet_drain_source_fault,
	.source_sense_overcurrent, .gate_mismatch, .regulator_undervoltage, .fault_indicator_n,
	.power_good_out, .gate_pulldown, .pump_enable, .driver_enable);

// >>> tb/host_model.sv
// host controller model: apb master and gate enable pin
`timescale 1ns/1ps
module host_model
(
	input wire logic clk,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [31:0] prdata,
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [11:0] paddr,
	output logic [31:0] pwdata,
	output logic gate_enable
);
	logic err;
	// ==========
	// bus idle, gate low at time zero
	initial
	begin
		{psel, penable, pwrite, paddr, pwdata, gate_enable} = '0;
		err = 1'b0;
	end
	// one transfer; status reads acknowledge warnings and feed the watchdog
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		// answer taken at the edge that sees ready
		err = pslverr;
		q = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		pwdata <= ~d;
	endtask
	// drop gate enable, configure in standby, raise it again
	task automatic setup(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] r;
		@(posedge clk) gate_enable <= 1'b0;
		repeat (4) @(posedge clk);
		if (a != 12'h000)
			xfer(1'b1, a, d, r);
		@(posedge clk) gate_enable <= 1'b1;
	endtask
endmodule

// >>> tb/testbench.sv
// self-checking bench for the fault class manager
`timescale 1ns/1ps
`include "fault_class_cfg.svh"
module testbench;
	import fault_class_pkg::*;
	logic clk, rst, psel, penable, pwrite, pready, pslverr, gate_enable;
	logic supply_lockout_level_two, overtemp_warning, overtemp_shutdown, pump_lockout;
	logic pump_undervoltage_warning, supply_undervoltage_warning, supply_overvoltage_warning;
	logic regulator_undervoltage, fault_indicator_n, power_good_out, gate_pulldown;
	logic pump_enable, driver_enable;
	logic [3:0] temp_flag, warn;
	logic [2:0] stop, source_sense_overcurrent;
	logic [5:0] fet_drain_source_fault, gate_mismatch;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, q;
	int error_cnt = 0;
	int check_count = 0;
	int n;
	localparam int WPOS[4] = '{0, 4, 6, 7};
	wire [4:0] pins = {power_good_out, driver_enable, pump_enable, gate_pulldown,
		fault_indicator_n};
	// ==========
	// causes fanned out to the inputs
	assign {supply_undervoltage_warning, supply_overvoltage_warning} = warn[3:2];
	assign {pump_undervoltage_warning, overtemp_warning} = warn[1:0];
	assign {overtemp_shutdown, pump_lockout, gate_mismatch} = {stop[0], stop[1], {6{stop[2]}}};
	fault_class_manager #(.WD_BASE(100)) u_fault_class_manager (.clk, .rst, .psel, .penable,
		.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .gate_enable,
		.supply_lockout_level_two, .temp_flag, .overtemp_warning, .overtemp_shutdown,
		.pump_undervoltage_warning, .supply_undervoltage_warning, .supply_overvoltage_warning,
		.pump_lockout, .fet_drain_source_fault, .source_sense_overcurrent, .gate_mismatch,
		.regulator_undervoltage, .fault_indicator_n, .power_good_out, .gate_pulldown,
		.pump_enable, .driver_enable);
	host_model u_host_model (.clk, .pready, .pslverr, .prdata, .psel, .penable, .pwrite,
		.paddr, .pwdata, .gate_enable);
	// clock and quiet inputs
	initial
	begin
		{supply_lockout_level_two, regulator_undervoltage, warn, stop} = '0;
		{temp_flag, source_sense_overcurrent, fet_drain_source_fault} = '0;
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	// hang guard
	initial
	begin
		repeat (40000) @(posedge clk);
		error_cnt++;
		wrap_up;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic cyc(input int c);
		repeat (c) @(negedge clk);
	endtask
	task automatic rdq(input logic [11:0] a);
		u_host_model.xfer(1'b0, a, 32'h0, q);
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] exp);
		rdq(a);
		chk(q, exp);
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		u_host_model.xfer(1'b1, a, d, q);
	endtask
	// cycles until the fault pin reaches a level
	task automatic wait_pin(input logic v);
		n = 0;
		while (fault_indicator_n !== v && n < 3000)
		begin
			@(negedge clk);
			n++;
		end
	endtask
	task automatic t_power;
		cyc(80);
		chk(pins[0], 1'b1);
		rd(`ADDR_STATE, 32'h2);
		rd(`ADDR_CTRL, `CTRL_RESET);
		u_host_model.setup(12'h000, 32'h0);
		cyc(6);
		rd(`ADDR_STATE, 32'h4);
		chk(pins, 5'h1D);
		wr(12'h0FC, 32'h7FF);
		chk(u_host_model.err, 1'b1);
		rd(`ADDR_STATE, 32'h4);
		chk(u_host_model.err, 1'b0);
		$display("power and bus test done");
	endtask
	task automatic t_temp;
		@(posedge clk) temp_flag <= 4'hF;
		cyc(6);
		chk(pins, 5'h1D);
		rdq(`ADDR_WARN);
		chk(q & 32'h10E, 32'h10E);
		@(posedge clk) temp_flag <= 4'h0;
		cyc(6);
		rdq(`ADDR_WARN);
		chk(q & 32'h10E, 32'h0);
		$display("temperature flag test done");
	endtask
	task automatic t_warn;
		for (int i = 0; i < 4; i++)
		begin
			@(posedge clk) warn[i] <= 1'b1;
			wait_pin(1'b0);
			wait_pin(1'b1);
			chk(n, 640);
			chk(pins, 5'h1D);
			rdq(`ADDR_WARN);
			chk(q[WPOS[i]], 1'b1);
			@(posedge clk) warn[i] <= 1'b0;
			cyc(4);
			rdq(`ADDR_WARN);
			chk(q[WPOS[i]], 1'b1);
			rdq(`ADDR_WARN);
			chk(q[WPOS[i]], 1'b0);
			cyc(1300);
			chk(pins[0], 1'b1);
		end
		$display("warning test done");
	endtask
	task automatic t_ocp;
		@(posedge clk) source_sense_overcurrent <= 3'h7;
		cyc(6);
		chk(pins, 5'h16);
		rd(`ADDR_STATE, 32'h2);
		wr(`ADDR_CTRL, 32'h2);
		cyc(4);
		rd(`ADDR_VDS, 32'h7);
		chk(pins[0], 1'b0);
		@(posedge clk) source_sense_overcurrent <= 3'h0;
		cyc(4);
		wr(`ADDR_CTRL, 32'h2);
		cyc(6);
		chk(pins[0], 1'b1);
		rd(`ADDR_VDS, 32'h0);
		rd(`ADDR_CTRL, 32'h0);
		u_host_model.setup(12'h000, 32'h0);
		$display("latched fault test done");
	endtask
	task automatic t_stop;
		for (int i = 0; i < 3; i++)
		begin
			@(posedge clk) stop[i] <= 1'b1;
			cyc(6);
			chk(pins, 5'h12);
			@(posedge clk) stop[i] <= 1'b0;
			u_host_model.setup(12'h000, 32'h0);
			cyc(6);
			chk(pins, 5'h1D);
		end
		$display("pump stop test done");
	endtask
	task automatic t_vds;
		for (int m = 0; m < 3; m++)
		begin
			u_host_model.setup(`ADDR_CTRL, m << `CTRL_VDS_MODE_POS);
			cyc(6);
			@(posedge clk) fet_drain_source_fault <= 6'h3F;
			cyc(6);
			chk(pins, {1'b1, m != 0, 1'b1, m == 0, m != 0});
			if (m == 1)
				wait_pin(1'b0);
			chk(fault_indicator_n, m == 2);
			rdq(`ADDR_VDS);
			chk(q & 32'h7E0, m == 2 ? 32'h0 : 32'h7E0);
			@(posedge clk) fet_drain_source_fault <= 6'h00;
			cyc(4);
			wr(`ADDR_CTRL, (m << `CTRL_VDS_MODE_POS) | 32'h2);
		end
		u_host_model.setup(`ADDR_CTRL, 32'h0);
		$display("drain-source mode test done");
	endtask
	task automatic t_wd;
		u_host_model.setup(`ADDR_CTRL, 32'h1 << `CTRL_WATCHDOG_ENABLE_BIT_POS);
		repeat (3)
		begin
			cyc(60);
			rdq(`ADDR_WARN);
		end
		chk(pins, 5'h1D);
		cyc(150);
		chk(pins, 5'h06);
		rd(`ADDR_CTRL, 32'h0);
		rdq(`ADDR_IC);
		chk(q[9], 1'b1);
		cyc(1400);
		chk(pins[4], 1'b1);
		@(posedge clk) regulator_undervoltage <= 1'b1;
		cyc(6);
		@(posedge clk) regulator_undervoltage <= 1'b0;
		cyc(1300);
		u_host_model.setup(12'h000, 32'h0);
		cyc(6);
		chk(pins, 5'h1D);
		rdq(`ADDR_IC);
		chk(q & 32'h240, 32'h0);
		$display("watchdog and regulator test done");
	endtask
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// reset, then the scenarios in turn
	initial
	begin
		rst = 1'b1;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		t_power;
		t_temp;
		t_warn;
		t_ocp;
		t_stop;
		t_vds;
		t_wd;
		wrap_up;
	end
endmodule
